// [design/ep0_ctrl_defs.vh]
// register offsets, field positions, reset values for the endpoint 0 block
`ifndef EP0_CTRL_DEFS_VH
`define EP0_CTRL_DEFS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_IN_COUNT        12'h000
`define OFF_IN_CTRL         12'h004
`define OFF_OUT_CTRL        12'h008
`define OFF_SETUP_CTRL      12'h00C
`define OFF_OUT_COUNT       12'h010
`define OFF_OUT_LEFT        12'h014
`define OFF_OUT_PTR         12'h018
`define OFF_IN_PTR          12'h01C
`define OFF_SETUP_PTR       12'h020
`define OFF_MODE            12'h024
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_ENABLE          0
`define BIT_STALL           1
`define BIT_PING            2
`define BIT_NO_RESP         7
`define BIT_HOST            0
`define BIT_HIGH_SPEED      1
// ----------------------------------------------------------------------
// reset values and fixed counts
// ----------------------------------------------------------------------
`define RST_COUNT           16'h0000
`define RST_CTRL            8'h00
`define RST_PTR             16'h0000
`define RST_MODE            2'b00
`define SETUP_BYTES         16'h0008
`endif

// [design/usb_ep0_transaction_ctrl.v]
// endpoint 0 control and byte-count registers with apb slave
`timescale 1ns/1ps
`include "ep0_ctrl_defs.vh"

module usb_ep0_transaction_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // completion reports from the transaction circuits, same clock
    input  wire        in_done,
    input  wire [15:0] in_received,
    input  wire        out_done,
    input  wire [15:0] out_received,
    // engine-facing controls
    output reg         in_stall,
    output reg         in_no_resp,
    output reg         out_enable,
    output reg         out_stall,
    output reg         out_ping,
    output reg         out_no_resp,
    output reg         setup_issue,
    output reg         setup_no_resp,
    output reg  [15:0] in_max_bytes,
    output reg  [15:0] out_xfer_bytes,
    output reg  [15:0] setup_store_bytes,
    output reg  [15:0] out_base_addr,
    output reg  [15:0] in_base_addr,
    output reg  [15:0] setup_base_addr
);

// ----------------------------------------------------------------------
// register storage
// ----------------------------------------------------------------------
// software-visible storage; every word resets to zero
reg  [15:0] in_count_q;
reg  [7:0]  in_ctrl_q;
reg  [7:0]  out_ctrl_q;
reg  [7:0]  setup_ctrl_q;
reg  [15:0] out_count_q;
reg  [15:0] out_left_q;
reg  [15:0] out_ptr_q;
reg  [15:0] in_ptr_q;
reg  [15:0] setup_ptr_q;
reg  [1:0]  mode_q;
reg  [31:0] rdata_d;
reg         hit_d;

// decoded mode, bus qualifiers and clamped write-back counts
wire        host_mode;
wire        high_speed;
wire        access;
wire        wr;
wire [15:0] in_clamped;
wire [15:0] out_clamped;
wire        setup_phase;
wire        in_count_we;
wire        in_ctrl_we;
wire        out_ctrl_we;
wire        setup_ctrl_we;
wire        out_count_we;
wire        out_left_we;
wire        out_ptr_we;
wire        in_ptr_we;
wire        setup_ptr_we;
wire        mode_we;

assign host_mode  = mode_q[`BIT_HOST];
assign high_speed = mode_q[`BIT_HIGH_SPEED];
// zero wait state: each access completes in its first access cycle
assign access     = psel & penable;
assign wr         = access & pwrite;

// received counts can never exceed the programmed maximum
// a short transaction simply reports fewer bytes
assign in_clamped  = (in_received > in_count_q) ? in_count_q
                                                : in_received;
assign out_clamped = (out_received > out_count_q) ? out_count_q
                                                  : out_received;

// ----------------------------------------------------------------------
// write strobes, one per register
// ----------------------------------------------------------------------
// full-address compare: an unmapped or unaligned offset writes nothing,
// which is what the error answer promises
assign in_count_we   = wr & (paddr == `OFF_IN_COUNT);
assign in_ctrl_we    = wr & (paddr == `OFF_IN_CTRL);
assign out_ctrl_we   = wr & (paddr == `OFF_OUT_CTRL);
assign setup_ctrl_we = wr & (paddr == `OFF_SETUP_CTRL);
assign out_count_we  = wr & (paddr == `OFF_OUT_COUNT);
assign out_left_we   = wr & (paddr == `OFF_OUT_LEFT);
assign out_ptr_we    = wr & (paddr == `OFF_OUT_PTR);
assign in_ptr_we     = wr & (paddr == `OFF_IN_PTR);
assign setup_ptr_we  = wr & (paddr == `OFF_SETUP_PTR);
assign mode_we       = wr & (paddr == `OFF_MODE);

// ----------------------------------------------------------------------
// address decode for reads
// ----------------------------------------------------------------------
// ptr and mode registers are extras needed to steer the engine
// unmapped offsets read zero and raise the error answer
always @* begin
    rdata_d = 32'h00000000;
    hit_d   = 1'b1;
    case (paddr)
        `OFF_IN_COUNT:   rdata_d = {16'h0000, in_count_q};
        `OFF_IN_CTRL:    rdata_d = {24'h000000, in_ctrl_q};
        `OFF_OUT_CTRL:   rdata_d = {24'h000000, out_ctrl_q};
        `OFF_SETUP_CTRL: rdata_d = 32'h00000000;
        `OFF_OUT_COUNT:  rdata_d = {16'h0000, out_count_q};
        `OFF_OUT_LEFT:   rdata_d = {16'h0000, out_left_q};
        `OFF_OUT_PTR:    rdata_d = {16'h0000, out_ptr_q};
        `OFF_IN_PTR:     rdata_d = {16'h0000, in_ptr_q};
        `OFF_SETUP_PTR:  rdata_d = {16'h0000, setup_ptr_q};
        `OFF_MODE:       rdata_d = {30'h0000000, mode_q};
        default:         hit_d   = 1'b0;
    endcase
end

// ----------------------------------------------------------------------
// apb answer: ready is a registered pulse during the access phase
// ----------------------------------------------------------------------
// a setup cycle is psel without penable; answering on the next edge
// gives zero wait states and needs no access-phase state machine
assign setup_phase = psel & ~penable;

// ready rises on the edge that ends the setup cycle so access completes at once
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
    end else begin
        pready <= setup_phase;
    end
end

// error flags an unmapped offset; such a write is dropped by the strobes
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pslverr <= 1'b0;
    end else begin
        pslverr <= setup_phase & ~hit_d;
    end
end

// read data only in the answer cycle, zero otherwise, so a stale
// word never lingers on the bus
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
        prdata <= rdata_d;
    end else begin
        prdata <= 32'h00000000;
    end
end

// ----------------------------------------------------------------------
// register writes and hardware write-back
// ----------------------------------------------------------------------
// one process per register keeps each priority plain: a hardware
// update wins over a software write in the same cycle, so a completion
// is never lost; software re-arms by writing the count again

// ep0_in_byte_count: maximum expected, then received count in host mode
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        in_count_q <= `RST_COUNT;
    end else if (in_done && host_mode) begin
        in_count_q <= in_clamped;
    end else if (in_count_we) begin
        in_count_q <= pwdata[15:0];
    end
end

// ep0_in_control: all eight bits kept so software reads back its value
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        in_ctrl_q <= `RST_CTRL;
    end else if (in_ctrl_we) begin
        in_ctrl_q <= pwdata[7:0];
    end
end

// ep0_out_control: enable, stall, ping and do-not-respond live here
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_ctrl_q <= `RST_CTRL;
    end else if (out_ctrl_we) begin
        out_ctrl_q <= pwdata[7:0];
    end
end

// setup_control: issue bit self-clears and acts only as a start pulse;
// a write in the same cycle wins over the clear
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        setup_ctrl_q <= `RST_CTRL;
    end else if (setup_ctrl_we) begin
        setup_ctrl_q <= pwdata[7:0];
    end else begin
        setup_ctrl_q[`BIT_ENABLE] <= 1'b0;
    end
end

// ep0_out_byte_count: bytes to send as host, maximum accepted as device
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_count_q <= `RST_COUNT;
    end else if (out_done && !host_mode) begin
        out_count_q <= out_clamped;
    end else if (out_count_we) begin
        out_count_q <= pwdata[15:0];
    end
end

// ep0_out_bytes_remaining: scratch word for software, drives nothing
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_left_q <= `RST_COUNT;
    end else if (out_left_we) begin
        out_left_q <= pwdata[15:0];
    end
end

// out buffer pointer: start of the out data in buffer ram
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_ptr_q <= `RST_PTR;
    end else if (out_ptr_we) begin
        out_ptr_q <= pwdata[15:0];
    end
end

// in buffer pointer: start of the in data in buffer ram
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        in_ptr_q <= `RST_PTR;
    end else if (in_ptr_we) begin
        in_ptr_q <= pwdata[15:0];
    end
end

// setup buffer pointer: zero after reset, so setup data that arrives
// before software is ready still lands at a known place
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        setup_ptr_q <= `RST_PTR;
    end else if (setup_ptr_we) begin
        setup_ptr_q <= pwdata[15:0];
    end
end

// mode: bit 0 host, bit 1 high speed; change it only while idle, as
// the stall and ping gating follows on the next edge
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mode_q <= `RST_MODE;
    end else if (mode_we) begin
        mode_q <= pwdata[1:0];
    end
end

// ----------------------------------------------------------------------
// engine controls, registered so every output comes from a flop
// ----------------------------------------------------------------------
// bits 3..6 of the control bytes are stored but drive nothing; the one
// cycle lag after a write is harmless, software arms before any token

// in transaction circuit controls
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        in_stall     <= 1'b0;
        in_no_resp   <= 1'b0;
        in_max_bytes <= `RST_COUNT;
        in_base_addr <= `RST_PTR;
    end else begin
        in_stall     <= ~host_mode & in_ctrl_q[`BIT_STALL];
        in_no_resp   <= in_ctrl_q[`BIT_NO_RESP];
        in_max_bytes <= in_count_q;
        in_base_addr <= in_ptr_q;
    end
end

// out buffer and out transaction circuit controls
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_enable     <= 1'b0;
        out_stall      <= 1'b0;
        out_ping       <= 1'b0;
        out_no_resp    <= 1'b0;
        out_xfer_bytes <= `RST_COUNT;
        out_base_addr  <= `RST_PTR;
    end else begin
        out_enable     <= out_ctrl_q[`BIT_ENABLE];
        out_stall      <= ~host_mode & out_ctrl_q[`BIT_STALL];
        out_ping       <= host_mode & high_speed
                          & out_ctrl_q[`BIT_PING];
        out_no_resp    <= out_ctrl_q[`BIT_NO_RESP];
        out_xfer_bytes <= out_count_q;
        out_base_addr  <= out_ptr_q;
    end
end

// setup transaction engine controls; there is no setup stall output,
// since a setup may never be refused
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        setup_issue       <= 1'b0;
        setup_no_resp     <= 1'b0;
        setup_store_bytes <= `SETUP_BYTES;
        setup_base_addr   <= `RST_PTR;
    end else begin
        // bits 1..2 assumed zero by software; ignored here
        setup_issue       <= host_mode & setup_ctrl_q[`BIT_ENABLE];
        setup_no_resp     <= setup_ctrl_q[`BIT_NO_RESP];
        // device side setup length is fixed whatever is programmed
        setup_store_bytes <= `SETUP_BYTES;
        setup_base_addr   <= setup_ptr_q;
    end
end

endmodule

// [verification/ep0_ctrl_asserts.sv]
// property checker for the endpoint 0 register block
`timescale 1ns/1ps
module ep0_ctrl_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        in_stall,
    input wire        out_stall,
    input wire        out_ping,
    input wire        setup_issue,
    input wire [15:0] setup_store_bytes
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // -------------------------------------------------------------
    // bus answer and read data
    // -------------------------------------------------------------
    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer after setup cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 0)
        else $error("error answer out of place");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_SETUP_RD: assert property (pready && !pwrite &&
        paddr == 12'h00C |-> prdata == 32'h0)
        else $error("write only byte read nonzero");
    AST_CTRL_HI: assert property (pready && !pwrite &&
        paddr inside {12'h004, 12'h008} |-> prdata[31:8] == 0)
        else $error("control read upper bits set");
    // -------------------------------------------------------------
    // engine controls; stall and ping belong to opposite modes
    // -------------------------------------------------------------
    AST_ISSUE_PULSE: assert property (setup_issue |=> !setup_issue)
        else $error("setup issue longer than a pulse");
    AST_EIGHT: assert property (setup_store_bytes == 16'h0008)
        else $error("setup store count not eight");
    AST_PING_HOST: assert property (out_ping |-> !out_stall && !in_stall)
        else $error("ping together with stall");
    AST_ISSUE_HOST: assert property (setup_issue |-> !in_stall && !out_stall)
        else $error("setup issued in device mode");
    cover property (setup_issue);
    cover property (pslverr);
    cover property (out_ping);
endmodule
bind usb_ep0_transaction_ctrl ep0_ctrl_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_stall(in_stall), .out_stall(out_stall), .out_ping(out_ping),
    .setup_issue(setup_issue), .setup_store_bytes(setup_store_bytes));

// [verification/ep0_engine_model.sv]
// far-side engine model: reports finished in and out transactions
`timescale 1ns/1ps
module ep0_engine_model (
    input  wire        pclk,
    output reg         in_done,
    output reg  [15:0] in_received,
    output reg         out_done,
    output reg  [15:0] out_received
);
    initial begin
        {in_done, out_done} = 2'b00;
        {in_received, out_received} = 32'h0;
    end
    // counts go stale after the pulse, so they are scrambled then
    task report(input dir_out, input [15:0] n, input integer gap);
        begin
            repeat (gap) @(posedge pclk);
            if (dir_out) {out_done, out_received} <= {1'b1, n};
            else {in_done, in_received} <= {1'b1, n};
            @(posedge pclk);
            {in_done, out_done} <= 2'b00;
            {in_received, out_received} <= {~n, ~n};
        end
    endtask
endmodule

// [verification/usb_ep0_transaction_ctrl_tb_top.sv]
// self-checking bench for the endpoint 0 register block
`timescale 1ns/1ps
module usb_ep0_transaction_ctrl_tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, in_done, out_done, in_stall, in_no_resp;
    wire out_enable, out_stall, out_ping, out_no_resp, setup_issue, setup_no_resp;
    wire [15:0] in_received, out_received, in_max_bytes, out_xfer_bytes;
    wire [15:0] setup_store_bytes, out_base_addr, in_base_addr, setup_base_addr;
    integer err_count = 0, cmp_count = 0, issues = 0, i, k, c, v;
    integer ref_q [0:9];
    always #25 pclk = ~pclk;
    always @(posedge pclk) if (setup_issue === 1'b1) issues <= issues + 1;
    usb_ep0_transaction_ctrl dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_done(in_done), .in_received(in_received), .out_done(out_done),
        .out_received(out_received), .in_stall(in_stall),
        .in_no_resp(in_no_resp), .out_enable(out_enable),
        .out_stall(out_stall), .out_ping(out_ping), .out_no_resp(out_no_resp),
        .setup_issue(setup_issue), .setup_no_resp(setup_no_resp),
        .in_max_bytes(in_max_bytes), .out_xfer_bytes(out_xfer_bytes),
        .setup_store_bytes(setup_store_bytes), .out_base_addr(out_base_addr),
        .in_base_addr(in_base_addr), .setup_base_addr(setup_base_addr));
    ep0_engine_model u_eng (.pclk(pclk), .in_done(in_done),
        .in_received(in_received), .out_done(out_done),
        .out_received(out_received));
    // -------------------------------------------------------------
    // compare, verdict and apb master
    // -------------------------------------------------------------
    task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // request held until pready is sampled high
    task xfer(input w, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            do begin @(posedge pclk); t = t + 1; end
            while (pready !== 1'b1 && t < 20);
            if (t >= 20) begin err_count = err_count + 1; report_and_stop; end
            {rd, er} = {prdata, pslverr};
            {psel, penable} <= 2'b00;
        end
    endtask
    // 8-bit control bytes sit at indices 1 to 3
    function [31:0] msk(input integer x);
        msk = (x >= 1 && x <= 3) ? 32'hFF : 32'hFFFF;
    endfunction
    task wr(input integer x, input [31:0] d);
        begin xfer(1'b1, {x[9:0], 2'b00}, d); ref_q[x] = d & msk(x); end
    endtask
    task rdc(input integer x);
        begin
            xfer(1'b0, {x[9:0], 2'b00}, 32'h0);
            chk("rdata", x == 3 ? 0 : ref_q[x], rd);
            chk("slverr", 0, er);
        end
    endtask
    // engine controls one cycle after storage; bits 3 to 6 random
    task eng(input h, input s);
        begin
            repeat (2) @(posedge pclk);
            chk("in_stall", !h & ref_q[1][1], in_stall);
            chk("out_stall", !h & ref_q[2][1], out_stall);
            chk("out_en", ref_q[2][0], out_enable);
            chk("ping", h & s & ref_q[2][2], out_ping);
            chk("no_resp", {ref_q[1][7], ref_q[2][7], ref_q[3][7]},
                {in_no_resp, out_no_resp, setup_no_resp});
            chk("counts", {ref_q[0][15:0], ref_q[4][15:0]},
                {in_max_bytes, out_xfer_bytes});
            chk("ptrs", {ref_q[6][15:0], ref_q[7][15:0], ref_q[8][15:0]},
                {out_base_addr, in_base_addr, setup_base_addr});
            chk("setup_n", 8, setup_store_bytes);
        end
    endtask
    initial begin
        void'($urandom(78));
        for (i = 0; i < 10; i = i + 1) ref_q[i] = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i = i + 1) rdc(i);
        xfer(1'b0, 12'h030, 32'h0);
        chk("unmapped", 1, er);
        // random contents in every mode; setup bits 0 to 2 kept zero
        for (k = 0; k < 4; k = k + 1) begin
            wr(9, k);
            for (i = 0; i < 9; i = i + 1)
                wr(i, $urandom & (i == 3 ? 32'hF8 : 32'hFFFFFFFF));
            for (i = 0; i < 9; i = i + 1) rdc(i);
            eng(k[0], k[1]);
        end
        // setup issue refused in device mode, one pulse in host mode
        v = issues;
        wr(9, 0);
        wr(3, 32'h01);
        eng(1'b0, 1'b0);
        @(posedge pclk);
        chk("no_issue", v, issues);
        wr(9, 3);
        wr(3, 32'h81);
        eng(1'b1, 1'b1);
        @(posedge pclk);
        chk("issues", v + 1, issues);
        // hardware count write-back, clamped, host in then device out
        for (k = 0; k < 4; k = k + 1) begin
            wr(9, k < 2);
            c = 4 + $urandom % 200;
            v = k[0] ? c + 3 : c - 1;
            wr(k < 2 ? 0 : 4, c);
            u_eng.report(k >= 2, v, 1 + 6 * k[0]);
            repeat (2) @(posedge pclk);
            ref_q[k < 2 ? 0 : 4] = v < c ? v : c;
            rdc(k < 2 ? 0 : 4);
        end
        report_and_stop;
    end
endmodule
